// ==== dcs_channel_regs.sv ====
// Status and register access logic of one disk channel controller.
// Assumes bus requests are one-cycle pulses synchronous to clk, at least
// two cycles apart, and that drive events arrive as synchronous pulses.
//
// Functional notes
// - corrected read sets status2 bit0, status1 bit9
// - successful retry sets status2 bit1, status1 bit9
// - initialize, task word, clear clear both indicators
// - status2 bits 2 to 12 read zero
// - status2 bit13 shows drive hardware fault
// - seek failure sets status2 bit14, status1 bit4
// - seek error holds until return to zero
// - write protect shown; writes then raise fault
// - code 3C returns firmware revision number
// - code 20 returns read retry count
// - retry count cleared by task, initialize, clear
// - 32 readable writable 16-bit registers per channel; registers 0D, 10 and 1E read back status2, retry count and revision instead
// - register number is channel plus code high bits
// - configuration word A code 01000X, channel 2 is 48
// - output sequence loads data into selected register
// - output address loads registers 04 and 05 high
// - input sequence returns selected register on data
// - response echoes request data on address bits
// - status1 bit9 recovered, cleared by initialize etc
`timescale 1ns/1ps
`default_nettype none
module dcs_channel_regs #(
  parameter logic [7:0] FW_REV = 8'h01  // Firmware revision, value is arbitrary
) (
  // Clock and reset (reset is the bus master clear)
  input  wire logic         clk,
  input  wire logic         rstn,
  // Bus request
  input  wire logic         bus_req,
  input  wire logic [1:0]   bus_chan,
  input  wire logic [5:0]   bus_fc,
  input  wire logic [15:0]  bus_data_in,
  input  wire logic [23:0]  bus_addr_in,
  // Bus response
  output logic              rsp_valid,
  output logic [15:0]       rsp_data,
  output logic [15:0]       rsp_addr_echo,
  // Drive and channel events
  input  wire logic         ev_corrected_read,
  input  wire logic         ev_retry_ok,
  input  wire logic         ev_retry_done,
  input  wire logic         ev_seek_fail,
  input  wire logic         ev_rtz_done,
  input  wire logic         ev_write_attempt,
  input  wire logic         hw_fault,
  input  wire logic         write_protect_sw,
  // Status outputs toward the first status word and the drive
  output logic              sw1_recovered,
  output logic              sw1_read_error,
  output logic              seek_error,
  output logic              device_fault
);
  import dcs_pkg::*;

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_ff;   // First stage, read only by the second
  logic rst_n_sync;    // Released copy used everywhere

  // Two flip-flops release the asynchronous reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_n_sync  <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_sync  <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic       is_write;     // Odd code writes
  logic       is_read;      // Even code reads
  logic       clr_cmd;      // Initialize or output task word
  logic [6:0] reg_num;      // Selected register number
  logic       addr_cmd;     // Output address command

  // Direction and selection from the function code
  always_comb begin
    is_write = bus_req && bus_fc[0];
    is_read  = bus_req && !bus_fc[0];
    reg_num  = {bus_chan, bus_fc[5:1]};
    addr_cmd = is_write && (bus_fc == FC_OUT_ADDR);
    clr_cmd  = is_write && ((bus_fc == FC_OUT_INIT) || (bus_fc == FC_OUT_TASK));
  end

  // ----------------------------------------------------------------
  // Register array write steering
  // ----------------------------------------------------------------
  logic       wa_en;        // Generic or low address write
  logic [6:0] wa_addr;      // Generic write entry
  logic [15:0] wa_data;     // Generic write data
  logic       wb_en;        // High byte write of register 05
  logic [6:0] wb_addr;      // High byte entry
  logic [15:0] rd_word;     // Register read data, one cycle late

  // Output address splits across registers 04 and 05
  always_comb begin
    if (addr_cmd) begin
      wa_en   = 1'b1;
      wa_addr = {bus_chan, REG_XFER_ADDR_LO};
      wa_data = bus_addr_in[15:0];
    end else begin
      wa_en   = is_write;
      wa_addr = reg_num;
      wa_data = bus_data_in;
    end
    wb_en   = addr_cmd;
    wb_addr = {bus_chan, REG_XFER_ADDR_HI};
  end

  // Register storage for all channels
  dcs_reg_file #(
    .AW (7),
    .DW (16)
  ) u_regs (
    .clk        (clk),
    .rst_n_sync (rst_n_sync),
    .wa_en      (wa_en),
    .wa_addr    (wa_addr),
    .wa_data    (wa_data),
    .wb_en      (wb_en),
    .wb_addr    (wb_addr),
    .wb_byte    (bus_addr_in[23:16]),
    .rd_addr    (reg_num),
    .rd_data_ff (rd_word)
  );

  // ----------------------------------------------------------------
  // Sticky status flags
  // ----------------------------------------------------------------
  logic corr_ff;            // Corrected read error
  logic retry_ok_ff;        // Successful retry
  logic seek_ff;            // Seek error
  logic rd_err_ff;          // First status word read error, seek part
  logic fault_ff;           // Write attempted under protection

  // Recovery indicators: a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      corr_ff     <= 1'b0;
      retry_ok_ff <= 1'b0;
    end else begin
      corr_ff     <= ev_corrected_read || (corr_ff && !clr_cmd);
      retry_ok_ff <= ev_retry_ok || (retry_ok_ff && !clr_cmd);
    end
  end

  // Seek error holds until return to zero; read error follows clears
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      seek_ff   <= 1'b0;
      rd_err_ff <= 1'b0;
    end else begin
      seek_ff   <= ev_seek_fail || (seek_ff && !ev_rtz_done);
      rd_err_ff <= ev_seek_fail || (rd_err_ff && !clr_cmd);
    end
  end

  // Write under protection gives a device fault until the switch drops
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= (write_protect_sw && ev_write_attempt)
                  || (fault_ff && write_protect_sw);
    end
  end

  // Status outputs
  always_comb begin
    sw1_recovered  = corr_ff || retry_ok_ff;
    sw1_read_error = rd_err_ff;
    seek_error     = seek_ff;
    device_fault   = fault_ff || hw_fault;
  end

  // ----------------------------------------------------------------
  // Read retry counter
  // ----------------------------------------------------------------
  logic [RETRY_W-1:0] retry_cnt_ff;   // Saturating retry count

  // Counts retries; a clear wins since it starts a new task
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      retry_cnt_ff <= '0;
    end else if (clr_cmd) begin
      retry_cnt_ff <= '0;
    end else if (ev_retry_done && retry_cnt_ff != '1) begin
      retry_cnt_ff <= retry_cnt_ff + RETRY_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Second status word
  // ----------------------------------------------------------------
  logic [15:0] sw2_word;    // Current second status word

  // Reserved positions stay zero
  always_comb begin
    sw2_word                = SW2_RESET;
    sw2_word[SW2_POS_CORR]  = corr_ff;
    sw2_word[SW2_POS_RETRY] = retry_ok_ff;
    sw2_word[SW2_POS_HWF]   = hw_fault;
    sw2_word[SW2_POS_SEEK]  = seek_ff;
    sw2_word[SW2_POS_WP]    = write_protect_sw;
  end

  // ----------------------------------------------------------------
  // Response pipeline
  // ----------------------------------------------------------------
  logic        st1_vld_ff;  // Read taken last cycle
  dcs_rsp_e    st1_kind_ff; // What that read returns
  logic [15:0] st1_echo_ff; // Request data to echo
  dcs_rsp_e    rsp_kind_ff; // Kind of the response on the bus
  dcs_rsp_e    nxt_kind;    // Kind of the incoming read

  // Special read codes take priority over the register array
  always_comb begin
    unique case (bus_fc)
      FC_IN_STATUS2: nxt_kind = DCS_RSP_SW2;
      FC_IN_FW_REV:  nxt_kind = DCS_RSP_FW;
      FC_IN_RETRY:   nxt_kind = DCS_RSP_RETRY;
      default:       nxt_kind = DCS_RSP_REG;
    endcase
  end

  // First stage waits for the array read
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      st1_vld_ff  <= 1'b0;
      st1_kind_ff <= DCS_RSP_REG;
      st1_echo_ff <= '0;
    end else begin
      st1_vld_ff  <= is_read;
      st1_kind_ff <= nxt_kind;
      st1_echo_ff <= bus_data_in;
    end
  end

  // Second stage drives the response from flip-flops
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rsp_valid     <= 1'b0;
      rsp_data      <= '0;
      rsp_addr_echo <= '0;
      rsp_kind_ff   <= DCS_RSP_REG;
    end else begin
      rsp_valid   <= st1_vld_ff;
      rsp_kind_ff <= st1_kind_ff;
      if (st1_vld_ff) begin
        rsp_addr_echo <= st1_echo_ff;
        unique case (st1_kind_ff)
          DCS_RSP_SW2:   rsp_data <= sw2_word;
          DCS_RSP_FW:    rsp_data <= {8'h00, FW_REV};
          DCS_RSP_RETRY: rsp_data <= {retry_cnt_ff, 8'h00};
          DCS_RSP_REG:   rsp_data <= rd_word;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_read_taken;
    bus_req && !bus_fc[0];
  endsequence

  sequence s_answer;
    ##RSP_LATENCY rsp_valid;
  endsequence

  a_corr_sets_both: assert property (@(posedge clk) disable iff (!rst_n_sync)
    ev_corrected_read |=> corr_ff && sw1_recovered)
    else $error("corrected read did not set both indicators");

  a_retry_sets_both: assert property (@(posedge clk) disable iff (!rst_n_sync)
    ev_retry_ok |=> retry_ok_ff && sw1_recovered)
    else $error("successful retry did not set both indicators");

  a_clear_flags: assert property (@(posedge clk) disable iff (!rst_n_sync)
    clr_cmd && !ev_corrected_read && !ev_retry_ok |=> !sw1_recovered)
    else $error("recovery indicators survived a clear");

  a_sw2_reserved: assert property (@(posedge clk) disable iff (!rst_n_sync)
    rsp_valid && rsp_kind_ff == DCS_RSP_SW2 |-> rsp_data[13:3] == 11'h000)
    else $error("reserved status bits not zero");

  a_hw_fault_bit: assert property (@(posedge clk) disable iff (!rst_n_sync)
    rsp_valid && rsp_kind_ff == DCS_RSP_SW2 |-> rsp_data[SW2_POS_HWF] == $past(hw_fault))
    else $error("hardware fault bit wrong");

  a_seek_sets: assert property (@(posedge clk) disable iff (!rst_n_sync)
    ev_seek_fail |=> seek_error && sw1_read_error)
    else $error("seek failure not flagged");

  a_seek_holds: assert property (@(posedge clk) disable iff (!rst_n_sync)
    seek_error && !ev_rtz_done |=> seek_error)
    else $error("seek error dropped without return to zero");

  a_wp_fault: assert property (@(posedge clk) disable iff (!rst_n_sync)
    write_protect_sw && ev_write_attempt |=> device_fault)
    else $error("protected write gave no fault");

  a_retry_clear: assert property (@(posedge clk) disable iff (!rst_n_sync)
    clr_cmd |=> retry_cnt_ff == '0)
    else $error("retry count not cleared");

  a_cfg_a_map: assert property (@(posedge clk) disable iff (!rst_n_sync)
    bus_req && bus_chan == 2'h2 && bus_fc == FC_CFG_A |-> reg_num == 7'h48)
    else $error("configuration word A register number wrong");

  a_addr_split: assert property (@(posedge clk) disable iff (!rst_n_sync)
    addr_cmd |-> wa_addr[4:0] == REG_XFER_ADDR_LO && wb_en && wa_data == bus_addr_in[15:0])
    else $error("output address not split");

  a_read_answer: assert property (@(posedge clk) disable iff (!rst_n_sync)
    s_read_taken |-> s_answer)
    else $error("read not answered after two cycles");

  a_echo_data: assert property (@(posedge clk) disable iff (!rst_n_sync)
    s_read_taken |-> ##2 rsp_addr_echo == $past(bus_data_in, 2))
    else $error("echo does not match request data");

  a_retry_place: assert property (@(posedge clk) disable iff (!rst_n_sync)
    rsp_valid && rsp_kind_ff == DCS_RSP_RETRY |-> rsp_data[7:0] == 8'h00)
    else $error("retry response reserved bits not zero");

endmodule
`default_nettype wire

// ==== dcs_cpu_model.sv ====
// CPU channel model: issues one bus request at a time and collects the answer.
// Assumes the block answers reads within four cycles of the taking edge.
`timescale 1ns/1ps
`default_nettype none
module dcs_cpu_model (
  // Clock and answer
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic [15:0] rsp_addr_echo,
  // Request
  output logic             bus_req,
  output logic [1:0]       bus_chan,
  output logic [5:0]       bus_fc,
  output logic [15:0]      bus_data_in,
  output logic [23:0]      bus_addr_in
);
  // -----------------------------------------------------------------
  // Idle state at time zero
  // -----------------------------------------------------------------
  initial begin
    bus_req     = 1'b0;
    bus_chan    = 2'h0;
    bus_fc      = 6'h00;
    bus_data_in = 16'h0000;
    bus_addr_in = 24'h000000;
  end

  // One request pulse, then a bounded wait for the read answer
  task automatic xfer(input logic [1:0] ch, input logic [5:0] fc, input logic [15:0] d,
                      input logic [23:0] a, output logic [15:0] rd,
                      output logic [15:0] echo, output bit got);
    int n;
    @(posedge clk);
    bus_req     <= 1'b1;
    bus_chan    <= ch;
    bus_fc      <= fc;
    bus_data_in <= d;
    bus_addr_in <= a;
    @(posedge clk);
    bus_req     <= 1'b0;
    // Released lines must not keep showing the old value
    bus_data_in <= ~d;
    bus_addr_in <= ~a;
    got  = 1'b0;
    rd   = 16'h0000;
    echo = 16'h0000;
    // Only even codes are answered
    if (!fc[0]) begin
      for (n = 0; n < 4 && !got; n++) begin
        @(posedge clk);
        #1;
        if (rsp_valid === 1'b1) begin
          got  = 1'b1;
          rd   = rsp_data;
          echo = rsp_addr_echo;
        end
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== dcs_pkg.sv ====
// Shared constants of the disk channel status and register block.
// Assumes a single 125 MHz clock; bus words use bit 0 as the most significant bit.
package dcs_pkg;

  // ----------------------------------------------------------------
  // Function codes (6 bits, low bit is the direction bit)
  // ----------------------------------------------------------------
  localparam logic [5:0] FC_IN_STATUS2   = 6'h1A;  // Input second status word
  localparam logic [5:0] FC_IN_FW_REV    = 6'h3C;  // Input firmware revision
  localparam logic [5:0] FC_IN_RETRY     = 6'h20;  // Input read retry counter
  localparam logic [5:0] FC_OUT_INIT     = 6'h01;  // Output control word, initialize
  localparam logic [5:0] FC_OUT_TASK     = 6'h07;  // Output task word
  localparam logic [5:0] FC_OUT_ADDR     = 6'h09;  // Output address
  localparam logic [5:0] FC_CFG_A        = 6'h10;  // Configuration word A, read form

  // ----------------------------------------------------------------
  // Register numbers inside one channel
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_XFER_ADDR_LO = 5'h04; // transfer_address_low
  localparam logic [4:0] REG_XFER_ADDR_HI = 5'h05; // transfer_address_high

  // ----------------------------------------------------------------
  // Second status word positions (data bus bit n sits at word bit 15-n)
  // ----------------------------------------------------------------
  localparam int SW2_POS_CORR  = 15;  // Corrected read error, bus bit 0
  localparam int SW2_POS_RETRY = 14;  // Successful retry, bus bit 1
  localparam int SW2_POS_HWF   = 2;   // Hardware fault, bus bit 13
  localparam int SW2_POS_SEEK  = 1;   // Seek error, bus bit 14
  localparam int SW2_POS_WP    = 0;   // Write protected, bus bit 15
  localparam logic [15:0] SW2_RESET = 16'h0000;  // Value after master clear

  // ----------------------------------------------------------------
  // Widths and latency
  // ----------------------------------------------------------------
  localparam int RETRY_W     = 8;   // Retry count field width
  localparam int RSP_LATENCY = 2;   // Request to response, in cycles

  // Kind of response being returned
  typedef enum logic [1:0] {
    DCS_RSP_REG,
    DCS_RSP_SW2,
    DCS_RSP_FW,
    DCS_RSP_RETRY
  } dcs_rsp_e;

endpackage

// ==== dcs_reg_file.sv ====
// Register array holding 32 words of 16 bits for each channel.
// Assumes the caller never writes the same entry on both ports in one cycle.
`timescale 1ns/1ps
`default_nettype none
module dcs_reg_file #(
  parameter int AW = 7,   // Register number width
  parameter int DW = 16   // Register width
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n_sync,
  // Generic write port
  input  wire logic          wa_en,
  input  wire logic [AW-1:0] wa_addr,
  input  wire logic [DW-1:0] wa_data,
  // High byte write port
  input  wire logic          wb_en,
  input  wire logic [AW-1:0] wb_addr,
  input  wire logic [7:0]    wb_byte,
  // Read port, data one cycle later
  input  wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0]      rd_data_ff
);
  import dcs_pkg::*;

  // Storage array
  logic [DW-1:0] mem [2**AW];

  // ----------------------------------------------------------------
  // Write ports, one generate entry per word
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2**AW; i++) begin : g_word
    always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
        mem[i] <= '0;
      end else if (wa_en && wa_addr == AW'(i)) begin
        mem[i] <= wa_data;
      end else if (wb_en && wb_addr == AW'(i)) begin
        mem[i] <= {wb_byte, mem[i][7:0]};     // Only the high byte changes
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered read
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ==== disk_channel_status_and_regs_tb.sv ====
// Self-checking bench of the disk channel status and register block.
// Assumes dcs_pkg and the CPU channel model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  end \
end
module disk_channel_status_and_regs_tb;
  import dcs_pkg::*;
  // -----------------------------------------------------------------
  // Signals and reference model state
  // -----------------------------------------------------------------
  localparam logic [7:0] FWV = 8'h5A;  // Revision number, value is arbitrary
  logic        clk, rstn, hw, wp;
  logic [5:0]  ev;        // corr, retry ok, retry done, seek fail, rtz, write
  logic        bus_req, rsp_valid, sw1_recovered, sw1_read_error, seek_error, device_fault;
  logic [1:0]  bus_chan, ch;
  logic [5:0]  bus_fc;
  logic [15:0] bus_data_in, rsp_data, rsp_addr_echo;
  logic [23:0] bus_addr_in, a;
  logic [4:0]  r;
  logic [1:0]  ch_l [12];
  logic [4:0]  r_l [12];
  logic [5:0]  clr [2] = '{FC_OUT_TASK, FC_OUT_INIT};
  int          mreg [128];  // Register array model
  int          corr, rty, seek, n, i, cyc, seed, err_total, checks_done;

  always #4 clk = ~clk;

  dcs_channel_regs #(.FW_REV(FWV)) dut (
    .clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_chan(bus_chan), .bus_fc(bus_fc),
    .bus_data_in(bus_data_in), .bus_addr_in(bus_addr_in), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_addr_echo(rsp_addr_echo), .ev_corrected_read(ev[0]),
    .ev_retry_ok(ev[1]), .ev_retry_done(ev[2]), .ev_seek_fail(ev[3]),
    .ev_rtz_done(ev[4]), .ev_write_attempt(ev[5]), .hw_fault(hw),
    .write_protect_sw(wp), .sw1_recovered(sw1_recovered),
    .sw1_read_error(sw1_read_error), .seek_error(seek_error),
    .device_fault(device_fault));

  dcs_cpu_model cpu (
    .clk(clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_addr_echo(rsp_addr_echo),
    .bus_req(bus_req), .bus_chan(bus_chan), .bus_fc(bus_fc), .bus_data_in(bus_data_in),
    .bus_addr_in(bus_addr_in));

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  // Expected second status word, bus bit n at word bit 15-n
  function automatic logic [15:0] sw2();
    return {corr[0], rty[0], 11'h000, hw, seek[0], wp};
  endfunction

  // Read with random echo data and compare
  task automatic rd_chk(input string nm, input logic [1:0] c, input logic [5:0] fc,
                        input logic [15:0] e);
    logic [15:0] d, rd, echo;
    bit          got;
    d = 16'($urandom);
    cpu.xfer(c, fc, d, 24'h000000, rd, echo, got);
    `CHK("answer", 1'b1, got)
    `CHK(nm, e, rd)
    `CHK("echo", d, echo)
  endtask

  // Write and update the model
  task automatic wr(input logic [1:0] c, input logic [5:0] fc, input logic [15:0] d,
                    input logic [23:0] ad);
    logic [15:0] rd, echo;
    bit          got;
    cpu.xfer(c, fc, d, ad, rd, echo, got);
    if (fc == FC_OUT_ADDR) begin
      mreg[{c, REG_XFER_ADDR_LO}] = ad[15:0];
      mreg[{c, REG_XFER_ADDR_HI}] = {ad[23:16], mreg[{c, REG_XFER_ADDR_HI}][7:0]};
    end else begin
      mreg[{c, fc[5:1]}] = d;
    end
    // Initialize and task word clear the recovery flags
    if (fc == FC_OUT_INIT || fc == FC_OUT_TASK) begin
      corr = 0;
      rty  = 0;
    end
  endtask

  // One-cycle event pulse, then one cycle for the flag to land
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
    @(posedge clk);
  endtask

  // Master clear held five cycles, first request four edges later
  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (mreg[j]) mreg[j] = 0;
    corr = 0;
    rty  = 0;
    seek = 0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      test_done();
    end
  end

  // -----------------------------------------------------------------
  // Tests
  // -----------------------------------------------------------------
  initial begin
    clk  = 1'b0;
    rstn = 1'b0;
    ev   = 6'h00;
    hw   = 1'b0;
    wp   = 1'b0;
    seed = $urandom(57790);
    do_reset();
    rd_chk("status2", 2'd0, FC_IN_STATUS2, sw2());
    rd_chk("retry", 2'd1, FC_IN_RETRY, 16'h0000);
    rd_chk("fwrev", 2'd3, FC_IN_FW_REV, {8'h00, FWV});
    $display("test reset values done");
    // Write all first, read back later so aliasing shows
    for (i = 0; i < 12; i++) begin
      ch = 2'($urandom);
      do r = 5'($urandom); while (r inside {5'h00, 5'h03, 5'h04, 5'h0D, 5'h10, 5'h1E});
      ch_l[i] = ch;
      r_l[i]  = r;
      wr(ch, {r, 1'b1}, 16'($urandom), 24'h000000);
    end
    for (i = 0; i < 12; i++) begin
      rd_chk("reg", ch_l[i], {r_l[i], 1'b0}, 16'(mreg[{ch_l[i], r_l[i]}]));
    end
    wr(2'd2, FC_CFG_A | 6'h01, 16'($urandom), 24'h000000);
    rd_chk("cfg_a", 2'd2, FC_CFG_A, 16'(mreg[7'h48]));
    a = 24'($urandom);
    wr(2'd1, 6'h0B, 16'h00A5, 24'h000000);
    wr(2'd1, FC_OUT_ADDR, 16'($urandom), a);
    rd_chk("addr_lo", 2'd1, 6'h08, a[15:0]);
    rd_chk("addr_hi", 2'd1, 6'h0A, {a[23:16], 8'hA5});
    $display("test register access done");
    foreach (clr[k]) begin
      pulse(0);
      corr = 1;
      rd_chk("status2", 2'd0, FC_IN_STATUS2, sw2());
      `CHK("recovered", 1'b1, sw1_recovered)
      pulse(1);
      rty = 1;
      rd_chk("status2", 2'd0, FC_IN_STATUS2, sw2());
      wr(2'(k), clr[k], 16'($urandom), 24'h000000);
      rd_chk("status2", 2'(k), FC_IN_STATUS2, sw2());
      `CHK("recovered", 1'b0, sw1_recovered)
    end
    pulse(1);
    do_reset();
    rd_chk("status2", 2'd0, FC_IN_STATUS2, sw2());
    $display("test recovery flags done");
    foreach (clr[k]) begin
      n = 1 + $urandom % 9;
      repeat (n) pulse(2);
      rd_chk("retry", 2'd2, FC_IN_RETRY, {8'(n), 8'h00});
      wr(2'd2, clr[k], 16'($urandom), 24'h000000);
      rd_chk("retry", 2'd2, FC_IN_RETRY, 16'h0000);
    end
    $display("test retry counter done");
    @(posedge clk);
    hw <= 1'b1;
    @(posedge clk);
    rd_chk("status2", 2'd3, FC_IN_STATUS2, sw2());
    `CHK("dev_fault", 1'b1, device_fault)
    @(posedge clk);
    hw <= 1'b0;
    wp <= 1'b1;
    @(posedge clk);
    rd_chk("status2", 2'd3, FC_IN_STATUS2, sw2());
    pulse(5);
    #1;
    `CHK("dev_fault", 1'b1, device_fault)
    @(posedge clk);
    wp <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("dev_fault", 1'b0, device_fault)
    $display("test faults done");
    pulse(3);
    seek = 1;
    #1;
    `CHK("seek", 1'b1, seek_error)
    `CHK("read_err", 1'b1, sw1_read_error)
    rd_chk("status2", 2'd0, FC_IN_STATUS2, sw2());
    wr(2'd0, FC_OUT_TASK, 16'($urandom), 24'h000000);
    rd_chk("status2", 2'd0, FC_IN_STATUS2, sw2());
    `CHK("read_err", 1'b0, sw1_read_error)
    pulse(4);
    seek = 0;
    rd_chk("status2", 2'd0, FC_IN_STATUS2, sw2());
    `CHK("seek", 1'b0, seek_error)
    $display("test seek error done");
    test_done();
  end
endmodule
`default_nettype wire
